/* File: core/acp_defines.svh */
// constants of the serial command port: command codes, field layouts, timing counts
`ifndef ACP_DEFINES_SVH
`define ACP_DEFINES_SVH
// command codes whose last bit does not matter, compared as their upper seven bits
`define ACP_TOP7_NOP          7'h00
`define ACP_TOP7_WAKE         7'h01
`define ACP_TOP7_SLEEP        7'h02
`define ACP_TOP7_RESTORE      7'h03
`define ACP_TOP7_BEGIN        7'h04
`define ACP_TOP7_HALT         7'h05
`define ACP_TOP7_RESULT_READ  7'h09
// full byte codes
`define ACP_CODE_SYS_OFFSET   8'h16
`define ACP_CODE_SYS_GAIN     8'h17
`define ACP_CODE_SELF_OFFSET  8'h19
// register access prefixes in bits [7:5]
`define ACP_PFX_REG_READ      3'h1
`define ACP_PFX_REG_WRITE     3'h2
`define ACP_PFX_REG_COUNT     3'h0
`define ACP_PFX_MSB           7
`define ACP_PFX_LSB           5
// one bit per command strobe on the command output
`define ACP_CI_WAKE           0
`define ACP_CI_SLEEP          1
`define ACP_CI_RESTORE        2
`define ACP_CI_BEGIN          3
`define ACP_CI_HALT           4
`define ACP_CI_SYS_OFFSET     5
`define ACP_CI_SYS_GAIN       6
`define ACP_CI_SELF_OFFSET    7
`define ACP_CMD_N             8
// result format and saturation limits
`define ACP_RESULT_W          16
`define ACP_SAT_HI            16'h7fff
`define ACP_SAT_LO            16'h8000
// timing in master clock periods
`define ACP_READY_GAP_MCLK    24
`define ACP_TIMEOUT_MCLK      32768
`define ACP_CMD_DELAY_MCLK    2
// bit positions within a byte, counted from zero
`define ACP_DECODE_BIT        3'h6
`define ACP_LAST_BIT          3'h7
`endif

/* File: core/acp_pkg.sv */
// types shared by the serial command port modules
package acp_pkg;
  typedef enum logic [3:0] {
    acp_st_cmd = 4'b0001,
    acp_st_cnt = 4'b0010,
    acp_st_rd  = 4'b0100,
    acp_st_wr  = 4'b1000
  } acp_state_type;
endpackage

/* File: core/acp_link_if.sv */
// sampled serial link events passed from the pin sampler to the port logic
`timescale 1ns/100ps
interface acp_link_if;
  logic sclk_rise;
  logic sclk_fall;
  logic din;
  logic selected;
  modport sampler (output sclk_rise, output sclk_fall, output din, output selected);
  modport core    (input sclk_rise, input sclk_fall, input din, input selected);
endinterface

/* File: core/acp_link_sampler.sv */
// two-flop synchronisers and edge detection for the serial pins
`timescale 1ns/100ps
module acp_link_sampler (
  input  wire logic  i_core_clk,
  input  wire logic  i_reset_n,
  input  wire logic  i_select_n,
  input  wire logic  i_sclk,
  input  wire logic  i_serial_in,
  acp_link_if.sampler link
);
  logic sclk_s1_reg;
  logic sclk_s2_reg;
  logic sclk_s3_reg;
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic din_s1_reg;
  logic din_s2_reg;

  // synchronise pins; edges are taken only from the second stage onward
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      cs_s1_reg   <= 1'b1;
      cs_s2_reg   <= 1'b1;
      din_s1_reg  <= 1'b0;
      din_s2_reg  <= 1'b0;
    end else begin
      sclk_s1_reg <= i_sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg   <= i_select_n;
      cs_s2_reg   <= cs_s1_reg;
      din_s1_reg  <= i_serial_in;
      din_s2_reg  <= din_s1_reg;
    end
  end

  // clock edges count only while selected
  // deselect masks clock
  assign link.selected  = ~cs_s2_reg;
  assign link.sclk_rise = sclk_s2_reg & ~sclk_s3_reg & ~cs_s2_reg;
  assign link.sclk_fall = ~sclk_s2_reg & sclk_s3_reg & ~cs_s2_reg;
  assign link.din       = din_s2_reg;
endmodule

/* File: core/acp_spi_port.sv */
// serial command port of the converter: command decode, result output and ready signalling
// Overview of operation
// - clock idles low, sample second edge
// - deselect resets port, floats shared output
// - ready pin reports regardless of select
// - capture on falling, update on rising
// - shared output falls with ready pin
// - ready pin high after power-on
// - continuous mode: first rising clock clears
// - unread result: pulse high 24 periods
// - new result overwrites previous one
// - optional timeout resets port after 2^15
// - results are 16-bit two's complement
// - results saturate at 7fff and 8000
// - decode nop, wake and sleep codes
// - decode restore, begin and halt codes
// - decode three calibration byte codes
// - decode result read code 12h/13h
// - register commands: prefix, address, count
// - register commands two bytes plus data
// - no result load during register access
// - decode seven-bit codes on seventh falling edge, full bytes on eighth
// - begin and halt act two periods later
// - register bytes msb first, zeros past end
`timescale 1ns/100ps
`include "acp_defines.svh"
module acp_spi_port import acp_pkg::*; #(
  parameter int RAW_W        = 18,
  parameter int NUM_REGS     = 18,
  parameter int MCLK_DIV     = 1,
  parameter int TIMEOUT_MCLK = `ACP_TIMEOUT_MCLK
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_select_n,
  input  wire logic                    i_sclk,
  input  wire logic                    i_serial_in,
  input  wire logic                    i_result_valid,
  input  wire logic signed [RAW_W-1:0] i_raw_result,
  input  wire logic                    i_continuous_mode,
  input  wire logic                    i_timeout_en,
  input  wire logic [7:0]              i_reg_rdata,
  output logic                         o_data_out,
  output logic                         o_data_out_oe_n,
  output logic                         o_data_ready_n,
  output logic [4:0]                   o_reg_addr,
  output logic [7:0]                   o_reg_wdata,
  output logic                         o_reg_wr,
  output logic [`ACP_CMD_N-1:0]        o_cmd_pulse
);
  localparam int TO_W  = $clog2(TIMEOUT_MCLK + 1);
  localparam int DIV_W = $clog2(MCLK_DIV + 1);
  localparam logic [TO_W-1:0]  TO_LIMIT = TO_W'(TIMEOUT_MCLK);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MCLK_DIV - 1);
  localparam logic [4:0]       GAP_LOAD = 5'(`ACP_READY_GAP_MCLK);

  // refuse parameter values the logic cannot serve
  if (RAW_W < `ACP_RESULT_W || NUM_REGS < 1 || NUM_REGS > 32 || MCLK_DIV < 1 || TIMEOUT_MCLK < 2) begin
    $error("acp_spi_port: unsupported parameter values");
  end

  function automatic logic [15:0] acp_saturate(input logic signed [RAW_W-1:0] v);
    logic signed [RAW_W-1:0] hi;
    logic signed [RAW_W-1:0] lo;
    hi = RAW_W'($signed(`ACP_SAT_HI));
    lo = -hi - RAW_W'(1);
    if (v > hi)
      return `ACP_SAT_HI;
    else if (v < lo)
      return `ACP_SAT_LO;
    else
      return v[15:0];
  endfunction

  acp_link_if link ();

  acp_link_sampler u_sampler (
    .i_core_clk  (i_core_clk),
    .i_reset_n   (i_reset_n),
    .i_select_n  (i_select_n),
    .i_sclk      (i_sclk),
    .i_serial_in (i_serial_in),
    .link        (link.sampler)
  );

  acp_state_type     state_reg;
  acp_state_type     state_next;
  logic [2:0]        bit_cnt_reg;
  logic [7:0]        in_reg;
  logic [15:0]       out_reg;
  logic [15:0]       out_next;
  logic              dout_reg;
  logic              xfer_reg;
  logic [5:0]        addr_reg;
  logic [4:0]        left_reg;
  logic              load_pend_reg;
  logic              rdata_pend_reg;
  logic [15:0]       hold_reg;
  logic              ready_n_reg;
  logic              ready_n_next;
  logic [4:0]        gap_cnt_reg;
  logic              seen_reg;
  logic [DIV_W-1:0]  div_reg;
  logic [TO_W-1:0]   to_cnt_reg;
  logic [2:0]        dly1_reg;
  logic [2:0]        dly2_reg;

  wire        fall      = link.sclk_fall;
  wire        rise      = link.sclk_rise;
  wire [7:0]  in_next   = {in_reg[6:0], link.din};
  wire [6:0]  top7      = in_next[6:0];
  wire        seventh   = fall && (bit_cnt_reg == `ACP_DECODE_BIT);
  wire        byte_done = fall && (bit_cnt_reg == `ACP_LAST_BIT);
  wire        in_cmd    = (state_reg == acp_st_cmd);
  wire        mclk_en   = (div_reg == DIV_LAST);
  wire        in_range  = ({1'b0, addr_reg[4:0]} < 6'(NUM_REGS));
  wire        last_byte = (left_reg == 5'h00);
  wire [4:0]  addr_inc  = 5'(addr_reg[4:0] + 5'h01); // next register address

  wire dec_7      = seventh && in_cmd;
  wire dec_wake   = dec_7 && (top7 == `ACP_TOP7_WAKE);
  wire dec_sleep  = dec_7 && (top7 == `ACP_TOP7_SLEEP);
  wire dec_rest   = dec_7 && (top7 == `ACP_TOP7_RESTORE);
  wire dec_begin  = dec_7 && (top7 == `ACP_TOP7_BEGIN);
  wire dec_halt   = dec_7 && (top7 == `ACP_TOP7_HALT);
  wire dec_rdata  = dec_7 && (top7 == `ACP_TOP7_RESULT_READ);
  // calibration codes need the full byte
  wire dec_8      = byte_done && in_cmd;
  wire dec_soff   = dec_8 && (in_next == `ACP_CODE_SYS_OFFSET);
  wire dec_sgain  = dec_8 && (in_next == `ACP_CODE_SYS_GAIN);
  wire dec_self   = dec_8 && (in_next == `ACP_CODE_SELF_OFFSET);
  wire dec_reg_read_cmd   = dec_8 && (in_next[`ACP_PFX_MSB:`ACP_PFX_LSB] == `ACP_PFX_REG_READ);
  wire dec_reg_write_cmd   = dec_8 && (in_next[`ACP_PFX_MSB:`ACP_PFX_LSB] == `ACP_PFX_REG_WRITE);
  wire cnt_ok     = (in_next[`ACP_PFX_MSB:`ACP_PFX_LSB] == `ACP_PFX_REG_COUNT);

  wire to_hit     = i_timeout_en && mclk_en && (to_cnt_reg >= TO_LIMIT - TO_W'(1));
  wire port_rst   = !link.selected || to_hit;

  // ready announcement: immediate, or after the gap when the last result went unread
  wire gap_end    = mclk_en && (gap_cnt_reg == 5'h01);
  wire announce   = (i_result_valid && ready_n_reg && (gap_cnt_reg == 5'h00)) || gap_end;
  wire load_res   = byte_done && rdata_pend_reg && in_cmd;
  wire load_ann   = announce && in_cmd && !rdata_pend_reg;
  wire show_ready = in_cmd && (bit_cnt_reg == 3'h0) && !xfer_reg;

  // delayed strobes for sleep, begin and halt
  wire [2:0] dly_dec  = {dec_halt, dec_begin, dec_sleep};
  wire [2:0] dly1_nxt = mclk_en ? dly_dec : (dly1_reg | dly_dec);
  wire [2:0] dly2_nxt = mclk_en ? dly1_reg : dly2_reg;
  wire [2:0] dly_fire = mclk_en ? dly2_reg : 3'h0;

  // command state sequencing
  // two command bytes then data bytes
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      acp_st_cmd: begin
        if (dec_reg_read_cmd || dec_reg_write_cmd)
          state_next = acp_st_cnt;
      end
      acp_st_cnt: begin
        if (byte_done)
          state_next = !cnt_ok ? acp_st_cmd : (addr_reg[5] ? acp_st_wr : acp_st_rd);
      end
      acp_st_rd, acp_st_wr: begin
        if (byte_done && last_byte)
          state_next = acp_st_cmd;
      end
    endcase
  end

  // output shift register load and shift
  // register bytes msb first, zero past the end
  // a new result replaces the old
  always_comb begin
    out_next = out_reg;
    if (load_pend_reg)
      out_next = {in_range ? i_reg_rdata : 8'h00, 8'h00};
    else if (load_res)
      out_next = hold_reg;
    else if (load_ann)
      out_next = i_result_valid ? acp_saturate(i_raw_result) : hold_reg; // gap end shows the held result
    else if (rise)
      out_next = {out_reg[14:0], 1'b0};
  end

  // ready flag: announce wins over every clear
  // first rising clock clears in continuous mode
  // unread result raises the pin for the gap
  always_comb begin
    ready_n_next = ready_n_reg;
    if (announce)
      ready_n_next = 1'b0;
    else if (i_result_valid && !ready_n_reg)
      ready_n_next = 1'b1;
    else if ((rise && i_continuous_mode) || dec_rdata)
      ready_n_next = 1'b1;
  end

  // divider, timeout counter and delayed strobes
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_reg    <= '0;
      to_cnt_reg <= '0;
      dly1_reg   <= 3'h0;
      dly2_reg   <= 3'h0;
    end else begin
      div_reg    <= mclk_en ? '0 : div_reg + DIV_W'(1);
      to_cnt_reg <= (port_rst || byte_done || (in_cmd && bit_cnt_reg == 3'h0)) ? '0 :
                    (mclk_en ? to_cnt_reg + TO_W'(1) : to_cnt_reg);
      dly1_reg   <= dly1_nxt;
      dly2_reg   <= dly2_nxt;
    end
  end

  // serial command state
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg      <= acp_st_cmd;
      bit_cnt_reg    <= 3'h0;
      in_reg         <= 8'h00;
      addr_reg       <= 6'h00;
      left_reg       <= 5'h00;
      load_pend_reg  <= 1'b0;
      rdata_pend_reg <= 1'b0;
      xfer_reg       <= 1'b0;
    end else if (port_rst) begin
      state_reg      <= acp_st_cmd;
      bit_cnt_reg    <= 3'h0;
      load_pend_reg  <= 1'b0;
      rdata_pend_reg <= 1'b0;
      xfer_reg       <= 1'b0;
    end else begin
      state_reg      <= state_next;
      bit_cnt_reg    <= fall ? bit_cnt_reg + 3'h1 : bit_cnt_reg;
      in_reg         <= fall ? in_next : in_reg;
      xfer_reg       <= announce ? 1'b0 : (xfer_reg | rise);
      rdata_pend_reg <= dec_rdata | (rdata_pend_reg & ~byte_done);
      load_pend_reg  <= (byte_done && state_reg == acp_st_cnt && cnt_ok && !addr_reg[5]) ||
                        (byte_done && state_reg == acp_st_rd && !last_byte);
      if (dec_reg_read_cmd || dec_reg_write_cmd)
        addr_reg <= {dec_reg_write_cmd, in_next[4:0]};
      else if (byte_done && (state_reg == acp_st_rd || state_reg == acp_st_wr))
        addr_reg <= {addr_reg[5], addr_inc};
      if (byte_done && state_reg == acp_st_cnt)
        left_reg <= in_next[4:0];
      else if (byte_done && !in_cmd && !last_byte)
        left_reg <= left_reg - 5'h01;
    end
  end

  // result hold, ready pin and gap counter
  // ready pin ignores select
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_reg    <= 16'h0000;
      ready_n_reg <= 1'b1;
      gap_cnt_reg <= 5'h00;
      seen_reg    <= 1'b0;
    end else begin
      ready_n_reg <= ready_n_next;
      seen_reg    <= seen_reg | announce;
      if (i_result_valid)
        hold_reg <= acp_saturate(i_raw_result);
      if (i_result_valid && !ready_n_reg && gap_cnt_reg == 5'h00)
        gap_cnt_reg <= GAP_LOAD;
      else if (mclk_en && gap_cnt_reg != 5'h00)
        gap_cnt_reg <= gap_cnt_reg - 5'h01;
    end
  end

  // pin and strobe outputs
  // shared output mirrors the ready pin while idle
  // float the shared output when deselected
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      out_reg         <= 16'h0000;
      dout_reg        <= 1'b0;
      o_data_out      <= 1'b1;
      o_data_out_oe_n <= 1'b1;
      o_data_ready_n  <= 1'b1;
      o_reg_addr      <= 5'h00;
      o_reg_wdata     <= 8'h00;
      o_reg_wr        <= 1'b0;
      o_cmd_pulse     <= '0;
    end else begin
      out_reg         <= out_next;
      dout_reg        <= rise ? out_reg[15] : dout_reg;
      o_data_out      <= (show_ready && !rise) ? ready_n_next : (rise ? out_reg[15] : dout_reg);
      o_data_out_oe_n <= !link.selected;
      o_data_ready_n  <= ready_n_next;
      o_reg_addr      <= (byte_done && state_reg == acp_st_rd) ? addr_inc : addr_reg[4:0]; // lead the read load
      o_reg_wdata     <= in_next;
      o_reg_wr        <= byte_done && state_reg == acp_st_wr && in_range && !port_rst;
      o_cmd_pulse     <= {dec_self, dec_sgain, dec_soff, dly_fire[2], dly_fire[1], dec_rest, dly_fire[0], dec_wake};
    end
  end

  chk_deselect_float: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !link.selected |=> o_data_out_oe_n) else $error("shared output driven while deselected");
  chk_ready_shared_out: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (link.selected && show_ready && !rise && !port_rst) |=> (o_data_out == o_data_ready_n))
    else $error("shared output does not follow ready");
  chk_rise_clears_ready: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (rise && i_continuous_mode && !announce) |=> o_data_ready_n) else $error("ready not cleared by clock");
  chk_gap_holds_high: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (gap_cnt_reg > 5'h01) |=> o_data_ready_n) else $error("ready low inside gap");
  chk_result_saturate: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_result_valid && i_raw_result > RAW_W'($signed(`ACP_SAT_HI))) |=> (hold_reg == `ACP_SAT_HI))
    else $error("positive result not clipped");
  chk_timeout_reset: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    to_hit |=> (state_reg == acp_st_cmd && bit_cnt_reg == 3'h0)) else $error("timeout did not reset port");
  chk_busy_no_load: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (announce && !in_cmd && !load_pend_reg && !rise) |=> $stable(out_reg)) else $error("result loaded during access");
  chk_begin_delay: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (dec_begin && MCLK_DIV == 1) |-> ##3 o_cmd_pulse[`ACP_CI_BEGIN]) else $error("begin strobe not delayed");
  chk_power_on_high: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !seen_reg |-> o_data_ready_n) else $error("ready low before any result");
endmodule

/* File: verification/acp_host_model.sv */
// host bus master model driving the serial command port pins
`timescale 1ns/100ps
module acp_host_model (
  output logic      o_sclk,
  output logic      o_select_n,
  output logic      o_serial_in,
  input  wire logic i_data_out,
  input  wire logic i_data_out_oe_n
);
  logic last_out;
  wire  pin_level;

  // a released pin reads back as the inverse of its last driven value
  always @(i_data_out or i_data_out_oe_n) begin
    if (!i_data_out_oe_n) begin
      last_out = i_data_out;
    end
  end
  assign pin_level = i_data_out_oe_n ? ~last_out : i_data_out;

  // idle pins: clock low, deselected, data in low
  initial begin
    o_sclk      = 1'b0;
    o_select_n  = 1'b1;
    o_serial_in = 1'b0;
  end

  task automatic set_select(input logic sel_n);
    #3 o_select_n = sel_n;
    #40;
  endtask

  // mode one, data low on readback
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    #3;
    for (int i = 0; i < nbits; i++) begin
      o_sclk      = 1'b1;
      o_serial_in = tx[7-i];
      #40 o_sclk = 1'b0;
      #40 rx = {rx[6:0], pin_level};
    end
    o_serial_in = 1'b0;
  endtask
endmodule

/* File: verification/tb_adc_spi_command_port.sv */
// self-checking testbench of the serial command port
`timescale 1ns/100ps
module tb_adc_spi_command_port;
  logic               clk;
  logic               rst_n;
  wire                sclk;
  wire                select_n;
  wire                serial_in;
  logic               result_valid;
  logic signed [17:0] raw_result;
  logic               cont_mode;
  logic               timeout_en;
  wire  [7:0]         reg_rdata;
  logic               data_out;
  logic               data_out_oe_n;
  logic               data_ready_n;
  logic [4:0]         reg_addr;
  logic [7:0]         reg_wdata;
  logic               reg_wr;
  logic [7:0]         cmd_pulse;
  logic [7:0]         seen_cmd;
  logic               clr_seen;
  logic [12:0]        wr_log [4];
  int                 wr_cnt = 0;
  int                 failures;
  int                 num_checks;

  acp_spi_port #(.TIMEOUT_MCLK(200)) u_dut (
    .i_core_clk        (clk),
    .i_reset_n         (rst_n),
    .i_select_n        (select_n),
    .i_sclk            (sclk),
    .i_serial_in       (serial_in),
    .i_result_valid    (result_valid),
    .i_raw_result      (raw_result),
    .i_continuous_mode (cont_mode),
    .i_timeout_en      (timeout_en),
    .i_reg_rdata       (reg_rdata),
    .o_data_out        (data_out),
    .o_data_out_oe_n   (data_out_oe_n),
    .o_data_ready_n    (data_ready_n),
    .o_reg_addr        (reg_addr),
    .o_reg_wdata       (reg_wdata),
    .o_reg_wr          (reg_wr),
    .o_cmd_pulse       (cmd_pulse)
  );

  acp_host_model u_host (
    .o_sclk          (sclk),
    .o_select_n      (select_n),
    .o_serial_in     (serial_in),
    .i_data_out      (data_out),
    .i_data_out_oe_n (data_out_oe_n)
  );

  // register file stand-in: data tells which address was read
  assign reg_rdata = {3'h5, reg_addr};

  // core clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // gather command strobes and register writes
  always @(posedge clk) begin
    seen_cmd <= (clr_seen || !rst_n) ? 8'h00 : (seen_cmd | cmd_pulse);
    if (reg_wr && wr_cnt < 4) begin
      wr_log[wr_cnt] <= {reg_addr, reg_wdata};
      wr_cnt         <= wr_cnt + 1;
    end
  end

  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_ready(input logic lvl);
    int n;
    n = 0;
    while (data_ready_n !== lvl && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n == 200) begin
      failures++;
      $display("unexpected ready wait: expected %b seen %b", lvl, data_ready_n);
      final_report();
    end
  endtask

  task automatic post_result(input logic [17:0] raw);
    @(posedge clk);
    result_valid <= 1'b1;
    raw_result   <= raw;
    @(posedge clk);
    result_valid <= 1'b0;
    raw_result   <= ~raw; // raw input only means something with the strobe
  endtask

  task automatic clear_seen();
    @(posedge clk);
    clr_seen <= 1'b1;
    @(posedge clk);
    clr_seen <= 1'b0;
  endtask

  task automatic send(input logic [7:0] b);
    logic [7:0] rx;
    u_host.xfer(b, 8, rx);
  endtask

  task automatic read_word(output logic [15:0] w);
    logic [7:0] hi;
    logic [7:0] lo;
    u_host.xfer(8'h00, 8, hi);
    u_host.xfer(8'h00, 8, lo);
    w = {hi, lo};
  endtask

  // announce, read back, check format and ready handling
  task automatic s_format();
    logic [17:0] raw [4] = '{18'h00001, 18'h3ffff, 18'h0ffff, 18'h20000};
    logic [15:0] exp [4] = '{16'h0001, 16'hffff, 16'h7fff, 16'h8000};
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      post_result(raw[i]);
      wait_ready(1'b0);
      u_host.set_select(1'b0);
      chk_bit("enable while selected", 1'b0, data_out_oe_n);
      chk_bit("shared pin announce", 1'b0, data_out);
      read_word(w);
      chk_word("result word", exp[i], w);
      chk_bit("ready after first rise", 1'b1, data_ready_n);
      u_host.set_select(1'b1);
    end
  endtask

  // unread result overwritten, ready gap measured while deselected
  task automatic s_overwrite();
    logic [15:0] w;
    int          n;
    post_result(18'h00005);
    wait_ready(1'b0);
    post_result(18'h00007);
    wait_ready(1'b1);
    n = 0;
    while (data_ready_n === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk_word("ready gap cycles", 16'd24, 16'(n));
    chk_bit("ready while deselected", 1'b0, data_ready_n);
    u_host.set_select(1'b0);
    read_word(w);
    chk_word("newest result", 16'h0007, w);
    u_host.set_select(1'b1);
  endtask

  // result fetched by both read command codes in single-shot mode
  task automatic s_result_cmd();
    logic [15:0] w;
    for (int i = 0; i < 2; i++) begin
      cont_mode <= 1'b0;
      post_result(18'h00040 + 18'(i));
      wait_ready(1'b0);
      u_host.set_select(1'b0);
      send(8'h12 + 8'(i));
      read_word(w);
      chk_word("result by command", 16'h0040 + 16'(i), w);
      u_host.set_select(1'b1);
    end
    cont_mode <= 1'b1;
  endtask

  // register write of two bytes from address 05h
  task automatic s_write();
    u_host.set_select(1'b0);
    send(8'h45);
    send(8'h01);
    send(8'h3c);
    send(8'hc3);
    cycles(6);
    u_host.set_select(1'b1);
    chk_word("write count", 16'd2, 16'(wr_cnt));
    chk_word("first write", 16'h053c, 16'(wr_log[0]));
    chk_word("second write", 16'h06c3, 16'(wr_log[1]));
  endtask

  // register read past the last address with a result arriving mid-read
  task automatic s_read();
    logic [7:0] b;
    u_host.set_select(1'b0);
    send(8'h30);
    send(8'h02);
    post_result(18'h00009);
    u_host.xfer(8'h00, 8, b);
    chk_word("first register", 16'h00b0, {8'h00, b});
    u_host.xfer(8'h00, 8, b);
    chk_word("last register", 16'h00b1, {8'h00, b});
    u_host.xfer(8'h00, 8, b);
    chk_word("past last register", 16'h0000, {8'h00, b});
    u_host.set_select(1'b1);
  endtask

  // every control code, calibration code and one undefined code
  task automatic s_commands();
    logic [7:0] code [15] = '{8'h00, 8'h04, 8'h05, 8'h02, 8'h03, 8'h06, 8'h07, 8'h08,
                              8'h09, 8'h0a, 8'h0b, 8'h16, 8'h17, 8'h19, 8'h1f};
    logic [7:0] exp  [15] = '{8'h00, 8'h02, 8'h02, 8'h01, 8'h01, 8'h04, 8'h04, 8'h08,
                              8'h08, 8'h10, 8'h10, 8'h20, 8'h40, 8'h80, 8'h00};
    for (int i = 0; i < 15; i++) begin
      clear_seen();
      u_host.set_select(1'b0);
      send(code[i]);
      cycles(6);
      u_host.set_select(1'b1);
      chk_word("command strobes", {8'h00, exp[i]}, {8'h00, seen_cmd});
    end
  endtask

  // clocks while deselected, then a half byte aborted by deselect
  task automatic s_abort();
    logic [7:0] b;
    clear_seen();
    u_host.xfer(8'h08, 8, b);
    cycles(6);
    chk_word("strobes while deselected", 16'h0000, {8'h00, seen_cmd});
    u_host.set_select(1'b0);
    u_host.xfer(8'hff, 4, b);
    u_host.set_select(1'b1);
    u_host.set_select(1'b0);
    send(8'h08);
    cycles(6);
    u_host.set_select(1'b1);
    chk_word("strobes after abort", 16'h0008, {8'h00, seen_cmd});
  endtask

  // stalled partial byte recovered by the serial timeout
  task automatic s_timeout();
    logic [7:0] b;
    timeout_en <= 1'b1;
    clear_seen();
    u_host.set_select(1'b0);
    u_host.xfer(8'hff, 3, b);
    cycles(300);
    send(8'h0a);
    cycles(6);
    u_host.set_select(1'b1);
    chk_word("strobes after timeout", 16'h0010, {8'h00, seen_cmd});
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst_n        = 1'b0;
    result_valid = 1'b0;
    raw_result   = 18'h00000;
    cont_mode    = 1'b1;
    timeout_en   = 1'b0;
    clr_seen     = 1'b0;
    failures     = 0;
    num_checks   = 0;
    cycles(4);
    rst_n <= 1'b1;
    cycles(4);
    chk_bit("ready after reset", 1'b1, data_ready_n);
    chk_bit("enable while deselected", 1'b1, data_out_oe_n);
    s_format();
    s_overwrite();
    s_result_cmd();
    s_write();
    s_read();
    s_commands();
    s_abort();
    s_timeout();
    final_report();
  end
endmodule
